/* File: shared/vic_defines.vh */
// constants for the video-input configuration register bank
// assumes an upstream serial front end that delivers decoded page accesses
// ----------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------
// Operation
// - a rising cable-sense edge seen while sync is valid or 0x05 bit 4 is set sets the plug flag, bit 1 of cable_plug_interrupt_flag
// - writing one clears the plug flag; writing zero leaves it alone
// - soft_and_sync_interrupt_enable bit 5 soft interrupt enable, bit 3 sync-found enable, reset zero
// - unplug_interrupt_enable bit 0 enables the cable-removed interrupt, reset zero; the bank only stores it, irq_q is the plug flag gated by plug_interrupt_enable
// - plug_interrupt_enable bit 1 enables the cable-inserted interrupt, reset zero
// - input_termination_control bits 4:2 pick termination trim 65 to 45 ohms, reset 010
// - input_termination_control bits 1:0 pick termination style 50, dual, 3k, open; reset 00
// - sync_invert_color_standard bit 7 inverts vertical sync, bit 6 horizontal sync
// - sync_invert_color_standard bit 2 picks yuv-to-rgb standard, zero 601, one 709
// - sync_invert_color_standard bit 0 picks rgb-to-yuv standard, zero 601, one 709
// - yuv_to_rgb_enable bit 2 turns yuv-to-rgb conversion on, reset zero
// - rgb_to_yuv_and_resample_enable bit 3 turns rgb-to-yuv conversion on, reset zero
// - rgb_to_yuv_and_resample_enable bit 2 turns the 4:2:2 to 4:4:4 upsampler on
// - rgb_to_yuv_and_resample_enable bit 1 turns the 4:4:4 to 4:2:2 downsampler on
// - clock_ratio_control bits 7:6 divide output clock by 1, 2 or 4; reset 00
// - clock_ratio_control bits 5:4 declare input pixel replication 1x, 2x or 4x
// - hotplug_output_value bit 0 sets the level driven on the hot-plug pin
// - hotplug_output_enable bit 0 hands hot-plug pin control to the value register
// - 256-byte read/write id memory at 0xFE and on the display channel
// - pages answer at 0x64 or 0x66, 0xA0 video, 0xF0 hot-plug
// - with 0x05 bit 4 set, input logic resets while sync is invalid
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH

// ----------------------------------------------------------------------
// page device addresses (8-bit form, read/write bit zero)
// ----------------------------------------------------------------------
`define VIC_PG_AON_A 8'h60
`define VIC_PG_AON_B 8'h62
`define VIC_PG_PHY_A 8'h64
`define VIC_PG_PHY_B 8'h66
`define VIC_PG_VIDEO 8'hA0
`define VIC_PG_HOTPLUG 8'hF0
`define VIC_PG_IDMEM 8'hFE

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define VIC_OFS_AUTO_RST 8'h05
`define VIC_OFS_PLUG_FLAG 8'h83
`define VIC_OFS_SOFT_SYNC_EN 8'h90
`define VIC_OFS_UNPLUG_EN 8'h91
`define VIC_OFS_PLUG_EN 8'h93
`define VIC_OFS_TERM 8'h82
`define VIC_OFS_SYNC_STD 8'h48
`define VIC_OFS_Y2R_EN 8'h49
`define VIC_OFS_R2Y_EN 8'h4A
`define VIC_OFS_CLK_RATIO 8'hBC
`define VIC_OFS_HP_VALUE 8'hE9
`define VIC_OFS_HP_ENABLE 8'hEA

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define VIC_B_AUTO_RST 4
`define VIC_B_PLUG_FLAG 1
`define VIC_B_SOFT_EN 5
`define VIC_B_SYNC_EN 3
`define VIC_B_UNPLUG_EN 0
`define VIC_B_PLUG_EN 1
`define VIC_F_TRIM_HI 4
`define VIC_F_TRIM_LO 2
`define VIC_F_TSEL_HI 1
`define VIC_F_TSEL_LO 0
`define VIC_B_VINV 7
`define VIC_B_HINV 6
`define VIC_B_Y2R_STD 2
`define VIC_B_R2Y_STD 0
`define VIC_B_Y2R_ON 2
`define VIC_B_R2Y_ON 3
`define VIC_B_UPS_ON 2
`define VIC_B_DNS_ON 1
`define VIC_F_ODIV_HI 7
`define VIC_F_ODIV_LO 6
`define VIC_F_REP_HI 5
`define VIC_F_REP_LO 4
`define VIC_B_HP_BIT 0

// ----------------------------------------------------------------------
// reset values and fixed read fields
// ----------------------------------------------------------------------
`define VIC_RST_AUTO_RST 1'b1
`define VIC_RST_TRIM 3'h2
`define VIC_RST_TSEL 2'h0
`define VIC_RST_RATIO 2'h0
`define VIC_RATIO_LOW_NIB 4'h4
`define VIC_ID_BYTES 256

`endif

/* File: src/vic_regs.v */
// video-input configuration and status register bank
// assumes a serial front end hands over one decoded access per request
// pulse (page address, offset, data) and waits for the ack; the display
// channel front end does the same for the id memory; sync and cable
// inputs arrive from pins and are synchronised here
`include "vic_defines.vh"

module vic_regs #(
  parameter ID_DEPTH = `VIC_ID_BYTES
) (
  input wire clk,
  input wire rst_b,
  // local host page access
  input wire host_req,
  input wire host_wr,
  input wire [7:0] host_dev_addr,
  input wire [7:0] host_offset,
  input wire [7:0] host_wdata,
  output reg host_ack_q,
  output reg host_hit_q,
  output reg [7:0] host_rdata_q,
  // display data channel access to the id memory
  input wire ddc_req,
  input wire ddc_wr,
  input wire [7:0] ddc_offset,
  input wire [7:0] ddc_wdata,
  output reg ddc_ack_q,
  output reg [7:0] ddc_rdata_q,
  // pins and receiver status
  input wire cable_sense_input,
  input wire sync_valid,
  input wire vsync_in,
  input wire hsync_in,
  output reg vsync_out_q,
  output reg hsync_out_q,
  output reg hotplug_out_q,
  output reg hotplug_oe_q,
  output reg irq_q,
  output reg input_soft_reset_q,
  // configuration seen by the datapath
  output reg [2:0] termination_trim_q,
  output reg [1:0] termination_select_q,
  output reg yuv_to_rgb_standard_q,
  output reg rgb_to_yuv_standard_q,
  output reg yuv_to_rgb_on_q,
  output reg rgb_to_yuv_on_q,
  output reg upsample_on_q,
  output reg downsample_on_q,
  output reg [1:0] output_clock_divider_q,
  output reg [1:0] input_replication_ratio_q,
  output reg out_clk_en_q,
  output reg pixel_take_q
);

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  reg [1:0] sense_sync_q;
  reg [1:0] valid_sync_q;
  reg [1:0] vs_sync_q;
  reg [1:0] hs_sync_q;
  reg sense_prev_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_sync_q <= 2'h0;
      valid_sync_q <= 2'h0;
      vs_sync_q <= 2'h0;
      hs_sync_q <= 2'h0;
      sense_prev_q <= 1'b0;
    end else begin
      sense_sync_q <= {sense_sync_q[0], cable_sense_input};
      valid_sync_q <= {valid_sync_q[0], sync_valid};
      vs_sync_q <= {vs_sync_q[0], vsync_in};
      hs_sync_q <= {hs_sync_q[0], hsync_in};
      sense_prev_q <= sense_sync_q[1];
    end
  end

  wire sense_s = sense_sync_q[1];
  wire valid_s = valid_sync_q[1];

  // --------------------------------------------------------------------
  // page and offset decode
  // --------------------------------------------------------------------
  reg pg_aon;
  reg pg_phy;
  reg pg_video;
  reg pg_hp;
  reg pg_mem;

  always @* begin
    pg_aon = 1'b0;
    pg_phy = 1'b0;
    pg_video = 1'b0;
    pg_hp = 1'b0;
    pg_mem = 1'b0;
    if (host_dev_addr == `VIC_PG_AON_A || host_dev_addr == `VIC_PG_AON_B) begin
      pg_aon = 1'b1;
    end else if (host_dev_addr == `VIC_PG_PHY_A ||
                 host_dev_addr == `VIC_PG_PHY_B) begin
      pg_phy = 1'b1;
    end else if (host_dev_addr == `VIC_PG_VIDEO) begin
      pg_video = 1'b1;
    end else if (host_dev_addr == `VIC_PG_HOTPLUG) begin
      pg_hp = 1'b1;
    end else if (host_dev_addr == `VIC_PG_IDMEM) begin
      pg_mem = 1'b1;
    end
  end

  wire page_hit = pg_aon | pg_phy | pg_video | pg_hp | pg_mem;
  wire host_w = host_req & host_wr;
  wire wr_aon = host_w & pg_aon & (host_offset == `VIC_OFS_AUTO_RST);
  wire wr_flag = host_w & pg_phy & (host_offset == `VIC_OFS_PLUG_FLAG);
  wire wr_soft = host_w & pg_phy & (host_offset == `VIC_OFS_SOFT_SYNC_EN);
  wire wr_unpl = host_w & pg_phy & (host_offset == `VIC_OFS_UNPLUG_EN);
  wire wr_plen = host_w & pg_phy & (host_offset == `VIC_OFS_PLUG_EN);
  wire wr_term = host_w & pg_phy & (host_offset == `VIC_OFS_TERM);
  wire wr_sstd = host_w & pg_video & (host_offset == `VIC_OFS_SYNC_STD);
  wire wr_y2r = host_w & pg_video & (host_offset == `VIC_OFS_Y2R_EN);
  wire wr_r2y = host_w & pg_video & (host_offset == `VIC_OFS_R2Y_EN);
  wire wr_ratio = host_w & pg_video & (host_offset == `VIC_OFS_CLK_RATIO);
  wire wr_hpv = host_w & pg_hp & (host_offset == `VIC_OFS_HP_VALUE);
  wire wr_hpe = host_w & pg_hp & (host_offset == `VIC_OFS_HP_ENABLE);
  wire wr_mem = host_w & pg_mem;

  // --------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------
  reg auto_soft_reset_q;
  reg soft_interrupt_enable_q;
  reg sync_found_irq_enable_q;
  reg cable_removed_irq_enable_q;
  reg cable_inserted_irq_enable_q;
  reg vsync_invert_q;
  reg hsync_invert_q;
  reg hotplug_drive_value_q;
  reg hotplug_drive_enable_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_soft_reset_q <= `VIC_RST_AUTO_RST;
      soft_interrupt_enable_q <= 1'b0;
      sync_found_irq_enable_q <= 1'b0;
      cable_removed_irq_enable_q <= 1'b0;
      cable_inserted_irq_enable_q <= 1'b0;
      termination_trim_q <= `VIC_RST_TRIM;
      termination_select_q <= `VIC_RST_TSEL;
      vsync_invert_q <= 1'b0;
      hsync_invert_q <= 1'b0;
      yuv_to_rgb_standard_q <= 1'b0;
      rgb_to_yuv_standard_q <= 1'b0;
      yuv_to_rgb_on_q <= 1'b0;
      rgb_to_yuv_on_q <= 1'b0;
      upsample_on_q <= 1'b0;
      downsample_on_q <= 1'b0;
      output_clock_divider_q <= `VIC_RST_RATIO;
      input_replication_ratio_q <= `VIC_RST_RATIO;
      hotplug_drive_value_q <= 1'b0;
      hotplug_drive_enable_q <= 1'b0;
    end else begin
      if (wr_aon) begin
        auto_soft_reset_q <= host_wdata[`VIC_B_AUTO_RST];
      end
      if (wr_soft) begin
        soft_interrupt_enable_q <= host_wdata[`VIC_B_SOFT_EN];
        sync_found_irq_enable_q <= host_wdata[`VIC_B_SYNC_EN];
      end
      if (wr_unpl) begin
        cable_removed_irq_enable_q <= host_wdata[`VIC_B_UNPLUG_EN];
      end
      if (wr_plen) begin
        cable_inserted_irq_enable_q <= host_wdata[`VIC_B_PLUG_EN];
      end
      if (wr_term) begin
        // unused trim codes are stored as written; the analog side owns them
        termination_trim_q <=
          host_wdata[`VIC_F_TRIM_HI:`VIC_F_TRIM_LO];
        termination_select_q <=
          host_wdata[`VIC_F_TSEL_HI:`VIC_F_TSEL_LO];
      end
      if (wr_sstd) begin
        vsync_invert_q <= host_wdata[`VIC_B_VINV];
        hsync_invert_q <= host_wdata[`VIC_B_HINV];
        yuv_to_rgb_standard_q <= host_wdata[`VIC_B_Y2R_STD];
        rgb_to_yuv_standard_q <= host_wdata[`VIC_B_R2Y_STD];
      end
      if (wr_y2r) begin
        yuv_to_rgb_on_q <= host_wdata[`VIC_B_Y2R_ON];
      end
      if (wr_r2y) begin
        rgb_to_yuv_on_q <= host_wdata[`VIC_B_R2Y_ON];
        upsample_on_q <= host_wdata[`VIC_B_UPS_ON];
        downsample_on_q <= host_wdata[`VIC_B_DNS_ON];
      end
      if (wr_ratio) begin
        output_clock_divider_q <=
          host_wdata[`VIC_F_ODIV_HI:`VIC_F_ODIV_LO];
        input_replication_ratio_q <=
          host_wdata[`VIC_F_REP_HI:`VIC_F_REP_LO];
      end
      if (wr_hpv) begin
        hotplug_drive_value_q <= host_wdata[`VIC_B_HP_BIT];
      end
      if (wr_hpe) begin
        hotplug_drive_enable_q <= host_wdata[`VIC_B_HP_BIT];
      end
    end
  end

  // --------------------------------------------------------------------
  // cable plug flag
  // --------------------------------------------------------------------
  // without auto soft reset the input logic stalls when sync is lost, so
  // edges are only seen while sync is valid or auto reset is on
  reg cable_plug_flag_q;
  wire detect_live = valid_s | auto_soft_reset_q;
  wire plug_rise = sense_s & ~sense_prev_q & detect_live;
  wire plug_clear = wr_flag & host_wdata[`VIC_B_PLUG_FLAG];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cable_plug_flag_q <= 1'b0;
    end else begin
      // a new edge in the clearing cycle wins over the clear
      cable_plug_flag_q <= plug_rise | (cable_plug_flag_q & ~plug_clear);
    end
  end

  // --------------------------------------------------------------------
  // pin-side outputs
  // --------------------------------------------------------------------
  wire soft_reset_now = auto_soft_reset_q & ~valid_s;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_soft_reset_q <= 1'b0;
      vsync_out_q <= 1'b0;
      hsync_out_q <= 1'b0;
      hotplug_out_q <= 1'b0;
      hotplug_oe_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      input_soft_reset_q <= soft_reset_now;
      if (soft_reset_now) begin
        vsync_out_q <= 1'b0;
        hsync_out_q <= 1'b0;
      end else begin
        vsync_out_q <= vs_sync_q[1] ^ vsync_invert_q;
        hsync_out_q <= hs_sync_q[1] ^ hsync_invert_q;
      end
      hotplug_out_q <= hotplug_drive_value_q;
      hotplug_oe_q <= hotplug_drive_enable_q;
      irq_q <= cable_plug_flag_q & cable_inserted_irq_enable_q;
    end
  end

  // --------------------------------------------------------------------
  // output clock divider and pixel replication enables
  // --------------------------------------------------------------------
  // both rates are enable pulses on clk; code 10 is unused and runs as 1x
  reg [1:0] div_cnt_q;
  reg [1:0] rep_cnt_q;
  reg [1:0] div_last;
  reg [1:0] rep_last;

  always @* begin
    div_last = 2'h0;
    rep_last = 2'h0;
    if (output_clock_divider_q == 2'h1) begin
      div_last = 2'h1;
    end else if (output_clock_divider_q == 2'h3) begin
      div_last = 2'h3;
    end
    if (input_replication_ratio_q == 2'h1) begin
      rep_last = 2'h1;
    end else if (input_replication_ratio_q == 2'h3) begin
      rep_last = 2'h3;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 2'h0;
      rep_cnt_q <= 2'h0;
      out_clk_en_q <= 1'b0;
      pixel_take_q <= 1'b0;
    end else if (soft_reset_now) begin
      div_cnt_q <= 2'h0;
      rep_cnt_q <= 2'h0;
      out_clk_en_q <= 1'b0;
      pixel_take_q <= 1'b0;
    end else begin
      out_clk_en_q <= (div_cnt_q >= div_last);
      pixel_take_q <= (rep_cnt_q >= rep_last);
      div_cnt_q <= (div_cnt_q >= div_last) ? 2'h0 : div_cnt_q + 2'h1;
      rep_cnt_q <= (rep_cnt_q >= rep_last) ? 2'h0 : rep_cnt_q + 2'h1;
    end
  end

  // --------------------------------------------------------------------
  // display id memory
  // --------------------------------------------------------------------
  // no reset: content is undefined until written; a same-cycle write from
  // both channels lets the local host win
  reg [7:0] id_mem [0:ID_DEPTH-1];

  always @(posedge clk) begin
    if (wr_mem) begin
      id_mem[host_offset] <= host_wdata;
    end else if (ddc_req && ddc_wr) begin
      id_mem[ddc_offset] <= ddc_wdata;
    end
  end

  // --------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    if (pg_mem) begin
      rd_mux = id_mem[host_offset];
    end else if (pg_aon && host_offset == `VIC_OFS_AUTO_RST) begin
      rd_mux[`VIC_B_AUTO_RST] = auto_soft_reset_q;
    end else if (pg_phy && host_offset == `VIC_OFS_PLUG_FLAG) begin
      rd_mux[`VIC_B_PLUG_FLAG] = cable_plug_flag_q;
    end else if (pg_phy && host_offset == `VIC_OFS_SOFT_SYNC_EN) begin
      rd_mux[`VIC_B_SOFT_EN] = soft_interrupt_enable_q;
      rd_mux[`VIC_B_SYNC_EN] = sync_found_irq_enable_q;
    end else if (pg_phy && host_offset == `VIC_OFS_UNPLUG_EN) begin
      rd_mux[`VIC_B_UNPLUG_EN] = cable_removed_irq_enable_q;
    end else if (pg_phy && host_offset == `VIC_OFS_PLUG_EN) begin
      rd_mux[`VIC_B_PLUG_EN] = cable_inserted_irq_enable_q;
    end else if (pg_phy && host_offset == `VIC_OFS_TERM) begin
      rd_mux[`VIC_F_TRIM_HI:`VIC_F_TRIM_LO] = termination_trim_q;
      rd_mux[`VIC_F_TSEL_HI:`VIC_F_TSEL_LO] = termination_select_q;
    end else if (pg_video && host_offset == `VIC_OFS_SYNC_STD) begin
      rd_mux[`VIC_B_VINV] = vsync_invert_q;
      rd_mux[`VIC_B_HINV] = hsync_invert_q;
      rd_mux[`VIC_B_Y2R_STD] = yuv_to_rgb_standard_q;
      rd_mux[`VIC_B_R2Y_STD] = rgb_to_yuv_standard_q;
    end else if (pg_video && host_offset == `VIC_OFS_Y2R_EN) begin
      rd_mux[`VIC_B_Y2R_ON] = yuv_to_rgb_on_q;
    end else if (pg_video && host_offset == `VIC_OFS_R2Y_EN) begin
      rd_mux[`VIC_B_R2Y_ON] = rgb_to_yuv_on_q;
      rd_mux[`VIC_B_UPS_ON] = upsample_on_q;
      rd_mux[`VIC_B_DNS_ON] = downsample_on_q;
    end else if (pg_video && host_offset == `VIC_OFS_CLK_RATIO) begin
      rd_mux = {output_clock_divider_q, input_replication_ratio_q,
                `VIC_RATIO_LOW_NIB};
    end else if (pg_hp && host_offset == `VIC_OFS_HP_VALUE) begin
      rd_mux[`VIC_B_HP_BIT] = hotplug_drive_value_q;
    end else if (pg_hp && host_offset == `VIC_OFS_HP_ENABLE) begin
      rd_mux[`VIC_B_HP_BIT] = hotplug_drive_enable_q;
    end
  end

  // --------------------------------------------------------------------
  // access answers
  // --------------------------------------------------------------------
  // every request is answered next cycle; a missed page shows only as hit
  // low so the front end can refuse the address on the wire
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_ack_q <= 1'b0;
      host_hit_q <= 1'b0;
      host_rdata_q <= 8'h00;
      ddc_ack_q <= 1'b0;
      ddc_rdata_q <= 8'h00;
    end else begin
      host_ack_q <= host_req;
      host_hit_q <= host_req & page_hit;
      if (host_req && !host_wr) begin
        host_rdata_q <= rd_mux;
      end
      ddc_ack_q <= ddc_req;
      if (ddc_req && !ddc_wr) begin
        ddc_rdata_q <= id_mem[ddc_offset];
      end
    end
  end

endmodule

/* File: verification/vic_regs_checker.sv */
// checker for the video-input register bank, bound into vic_regs
// assumes one clock domain with rst_b as its asynchronous reset
module vic_regs_checker (
  input wire clk,
  input wire rst_b,
  input wire host_req,
  input wire host_wr,
  input wire [7:0] host_dev_addr,
  input wire [7:0] host_offset,
  input wire [7:0] host_wdata,
  input wire host_ack_q,
  input wire host_hit_q,
  input wire [7:0] host_rdata_q,
  input wire ddc_req,
  input wire ddc_ack_q,
  input wire hotplug_out_q,
  input wire hotplug_oe_q,
  input wire input_soft_reset_q,
  input wire vsync_out_q,
  input wire out_clk_en_q,
  input wire [1:0] output_clock_divider_q
);
  timeunit 1ns;
  timeprecision 100ps;
  wire known_pg = host_dev_addr inside {8'h60, 8'h62, 8'h64, 8'h66,
    8'hA0, 8'hF0, 8'hFE};
  wire hp_wr = host_req && host_wr && host_dev_addr == 8'hF0;
  wire lvl_wr = hp_wr && host_offset == 8'hE9;
  wire oe_wr = hp_wr && host_offset == 8'hEA;
  // ---
  // assertions
  // ---
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_host_ack: assert property (host_req |=> host_ack_q)
    else $error("host request not acknowledged");
  a_ddc_ack: assert property (ddc_req |=> ddc_ack_q)
    else $error("display channel request not acknowledged");
  a_read_hold: assert property (!(host_req && !host_wr) |=>
    $stable(host_rdata_q)) else $error("read data moved without a read");
  a_page_miss: assert property (host_req && !known_pg |=> !host_hit_q)
    else $error("hit on an unmapped page");
  // guard against a second write so the expected level is unambiguous
  a_hp_level: assert property (lvl_wr ##1 (!lvl_wr) [*2] |=>
    hotplug_out_q == $past(host_wdata[0], 3))
    else $error("hot-plug level does not follow its write");
  a_hp_drive: assert property (oe_wr ##1 (!oe_wr) [*2] |=>
    hotplug_oe_q == $past(host_wdata[0], 3))
    else $error("hot-plug drive enable does not follow its write");
  a_soft_quiet: assert property (input_soft_reset_q &&
    $past(input_soft_reset_q) |-> !out_clk_en_q && !vsync_out_q)
    else $error("outputs active during input soft reset");
  // the first edge after reset still shows the reset-time enable
  a_div_one: assert property (output_clock_divider_q == 2'h0 &&
    $stable(output_clock_divider_q) && !input_soft_reset_q &&
    !$past(input_soft_reset_q) && $past(rst_b) |-> out_clk_en_q)
    else $error("divide by one missed a clock enable");
  a_div_four: assert property (out_clk_en_q &&
    output_clock_divider_q == 2'h3 && $stable(output_clock_divider_q)
    |=> !out_clk_en_q [*3]) else $error("divide by four enable too soon");
endmodule

bind vic_regs vic_regs_checker u_vic_regs_checker (.clk, .rst_b, .host_req,
  .host_wr, .host_dev_addr, .host_offset, .host_wdata, .host_ack_q,
  .host_hit_q, .host_rdata_q, .ddc_req, .ddc_ack_q, .hotplug_out_q,
  .hotplug_oe_q, .input_soft_reset_q, .vsync_out_q, .out_clk_en_q,
  .output_clock_divider_q);

/* File: verification/vic_src.sv */
// cable and upstream video source model driving the receiver pins
// assumes the bench commands plug state, video and sync levels
module vic_src (
  input wire logic clk,
  input wire logic plugged,
  input wire logic video_on,
  input wire logic vs_lev,
  input wire logic hs_lev,
  output logic cable_sense_input,
  output logic sync_valid,
  output logic vsync_in,
  output logic hsync_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {cable_sense_input, sync_valid, vsync_in, hsync_in} = 4'h0;
  end
  // syncs only toggle while video runs, as a real source would
  always @(posedge clk) begin
    cable_sense_input <= plugged;
    sync_valid <= video_on;
    vsync_in <= video_on & vs_lev;
    hsync_in <= video_on & hs_lev;
  end
endmodule

/* File: verification/vic_regs_tb.sv */
// self-checking bench for the video-input register bank
// assumes vic_regs with its bound checker and the vic_src pin model
module vic_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, host_req, host_wr, ddc_req, ddc_wr;
  logic [7:0] host_dev_addr, host_offset, host_wdata, ddc_offset, ddc_wdata;
  logic plugged, video_on, vs_lev, hs_lev;
  wire cable_sense_input, sync_valid, vsync_in, hsync_in;
  wire host_ack_q, host_hit_q, ddc_ack_q, vsync_out_q, hsync_out_q, irq_q;
  wire hotplug_out_q, hotplug_oe_q, input_soft_reset_q, out_clk_en_q;
  wire yuv_to_rgb_standard_q, rgb_to_yuv_standard_q, yuv_to_rgb_on_q;
  wire rgb_to_yuv_on_q, upsample_on_q, downsample_on_q, pixel_take_q;
  wire [7:0] host_rdata_q, ddc_rdata_q;
  wire [2:0] termination_trim_q;
  wire [1:0] termination_select_q, output_clock_divider_q;
  wire [1:0] input_replication_ratio_q;
  int err_total, num_checks, cyc, n, m;
  logic [8:0] hq[$];
  logic [7:0] dq[$];
  logic [7:0] d, a;
  logic [7:0] wv[10];
  logic [7:0] pg[10] = '{8'hA0, 8'hA0, 8'hA0, 8'hA0, 8'h64, 8'hF0, 8'hF0,
    8'h64, 8'h64, 8'h66};
  logic [7:0] ofs[10] = '{8'h48, 8'h49, 8'h4A, 8'hBC, 8'h82, 8'hE9, 8'hEA,
    8'h90, 8'h91, 8'h93};
  logic [7:0] mk[10] = '{8'hC5, 8'h04, 8'h0E, 8'hF0, 8'h1F, 8'h01, 8'h01,
    8'h28, 8'h01, 8'h02};
  logic [7:0] cv[3] = '{8'h00, 8'h50, 8'hF0};
  logic [8:0] cnt[3] = '{9'h010, 9'h008, 9'h004};

  vic_regs u_vic_regs (.clk, .rst_b, .host_req, .host_wr, .host_dev_addr,
    .host_offset, .host_wdata, .host_ack_q, .host_hit_q, .host_rdata_q,
    .ddc_req, .ddc_wr, .ddc_offset, .ddc_wdata, .ddc_ack_q, .ddc_rdata_q,
    .cable_sense_input, .sync_valid, .vsync_in, .hsync_in, .vsync_out_q,
    .hsync_out_q, .hotplug_out_q, .hotplug_oe_q, .irq_q, .input_soft_reset_q,
    .termination_trim_q, .termination_select_q, .yuv_to_rgb_standard_q,
    .rgb_to_yuv_standard_q, .yuv_to_rgb_on_q, .rgb_to_yuv_on_q,
    .upsample_on_q, .downsample_on_q, .output_clock_divider_q,
    .input_replication_ratio_q, .out_clk_en_q, .pixel_take_q);
  vic_src u_vic_src (.clk, .plugged, .video_on, .vs_lev, .hs_lev,
    .cable_sense_input, .sync_valid, .vsync_in, .hsync_in);

  // ---
  // tasks
  // ---
  task chk(input logic [8:0] got, want);
    num_checks++;
    if (got !== want) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task final_report();
    if (hq.size() + dq.size() != 0) begin
      err_total++;
      $display("mismatch at %0t: reads left unanswered", $time);
    end
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // request held one edge, then one idle edge while the ack comes back
  task acc(input logic w, input logic [7:0] dv, o, v);
    host_wr = w;
    host_dev_addr = dv;
    host_offset = o;
    host_wdata = v;
    host_req = 1'b1;
    @(posedge clk) #1;
    host_req = 1'b0;
    @(posedge clk) #1;
  endtask
  task wr(input logic [7:0] dv, o, v);
    acc(1'b1, dv, o, v);
  endtask
  task rd(input logic [7:0] dv, o, input logic [8:0] e);
    hq.push_back(e);
    acc(1'b0, dv, o, 8'h00);
  endtask
  task dacc(input logic w, input logic [7:0] o, v);
    ddc_wr = w;
    ddc_offset = o;
    ddc_wdata = v;
    ddc_req = 1'b1;
    @(posedge clk) #1;
    ddc_req = 1'b0;
    @(posedge clk) #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      final_report();
    end
  end
  // acks arrive on a rising edge, so sample them at the falling edge
  always @(negedge clk) begin
    if (host_ack_q === 1'b1 && hq.size() > 0)
      chk({host_hit_q, host_rdata_q}, hq.pop_front());
    if (ddc_ack_q === 1'b1 && dq.size() > 0)
      chk({1'b0, ddc_rdata_q}, {1'b0, dq.pop_front()});
  end

  // ---
  // sequence
  // ---
  initial begin
    {rst_b, host_req, host_wr, ddc_req, ddc_wr} = 5'h00;
    {host_dev_addr, host_offset, host_wdata, ddc_offset, ddc_wdata} = '0;
    {plugged, video_on, vs_lev, hs_lev} = 4'h0;
    d = 8'($urandom(58));
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk({4'h0, termination_trim_q, termination_select_q}, 9'h008);
    chk({7'h0, hotplug_oe_q, hotplug_out_q}, 9'h000);
    rd(8'h64, 8'h90, 9'h100);
    rd(8'h64, 8'h91, 9'h100);
    rd(8'h64, 8'h93, 9'h100);
    rd(8'hA0, 8'hBC, 9'h104);
    rd(8'hA0, 8'h4A, 9'h100);
    rd(8'hA0, 8'h49, 9'h100);
    chk({8'h0, input_soft_reset_q}, 9'h001);
    wr(8'h60, 8'h05, 8'h00);
    chk({8'h0, input_soft_reset_q}, 9'h000);
    plugged = 1'b1;
    #100;
    rd(8'h64, 8'h83, 9'h100);
    plugged = 1'b0;
    #50;
    wr(8'h60, 8'h05, 8'h10);
    rd(8'h62, 8'h05, 9'h110);
    wr(8'h64, 8'h93, 8'h02);
    plugged = 1'b1;
    #100;
    chk({8'h0, irq_q}, 9'h001);
    rd(8'h64, 8'h83, 9'h102);
    wr(8'h64, 8'h93, 8'h00);
    chk({8'h0, irq_q}, 9'h000);
    wr(8'h64, 8'h83, 8'hFD);
    rd(8'h64, 8'h83, 9'h102);
    wr(8'h64, 8'h83, 8'h02);
    rd(8'h64, 8'h83, 9'h100);
    video_on = 1'b1;
    for (int i = 0; i < 10; i++) begin
      wv[i] = 8'($urandom());
      wr(pg[i], ofs[i], wv[i]);
      d = wv[i] & mk[i] | (i == 3 ? 8'h04 : 8'h00);
      rd(pg[i], ofs[i], {1'b1, d});
    end
    chk({4'h0, termination_trim_q, termination_select_q},
      {4'h0, wv[4][4:0]});
    chk({6'h0, yuv_to_rgb_standard_q, rgb_to_yuv_standard_q, yuv_to_rgb_on_q},
      {6'h0, wv[0][2], wv[0][0], wv[1][2]});
    chk({6'h0, rgb_to_yuv_on_q, upsample_on_q, downsample_on_q},
      {6'h0, wv[2][3:1]});
    chk({5'h0, output_clock_divider_q, input_replication_ratio_q},
      {5'h0, wv[3][7:4]});
    chk({7'h0, hotplug_oe_q, hotplug_out_q},
      {7'h0, wv[6][0], wv[5][0]});
    rd(8'h70, 8'h48, 9'h000);
    rd(8'hA0, 8'h50, 9'h100);
    vs_lev = 1'b1;
    hs_lev = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(8'hA0, 8'h48, {k[1:0], 6'h00});
      #60;
      chk({7'h0, vsync_out_q, hsync_out_q}, {7'h0, ~k[1:0]});
    end
    for (int j = 0; j < 2; j++) begin
      a = j ? 8'hFF : 8'h00;
      d = 8'($urandom());
      dacc(1'b1, a, d);
      rd(8'hFE, a, {1'b1, d});
      wr(8'hFE, a, ~d);
      dq.push_back(~d);
      dacc(1'b0, a, 8'h00);
    end
    for (int c = 0; c < 3; c++) begin
      wr(8'hA0, 8'hBC, cv[c]);
      #40;
      n = 0;
      m = 0;
      repeat (16) begin
        #10;
        n += out_clk_en_q;
        m += pixel_take_q;
      end
      chk(9'(n), cnt[c]);
      chk(9'(m), cnt[c]);
    end
    final_report();
  end
endmodule
